// file: hw/pfrp_top.v
// program flash read port: register slave, fetch sequencer and flash port
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pfrp_consts.vh"
// Contract
// - flash words are read by software during normal execution with no special mode.
// - the fetched word is chosen by the combined high and low address registers at start.
// - only a write of one to bit 0 of the control register starts a read.
// - the fetch takes two instruction cycles after the start bit is set.
// - the second instruction after the start is discarded while the array is busy.
// - on completion the low byte goes to the low data register, upper bits to the high one.
// - code protection does not block or change these reads.
// - hardware clears the start bit at completion and a software zero write has no effect.
// - control register bits 6 to 1 read as zero.
// - high data bits 5 to 0 hold the upper six bits of the fetched word.
// - high data bits 7 and 6 read as zero.
// - high address bits 4 to 0 give flash address bits 12 to 8.
module pfrp_top (
   input  wire                      core_clk,
   input  wire                      rst,
   input  wire                      clk_en,
   input  wire [`PFRP_ADDR_W-1:0]   reg_addr,
   input  wire [7:0]                reg_wdata,
   input  wire                      reg_write,
   input  wire                      reg_read,
   output reg  [7:0]                reg_rdata,
   output reg  [`PFRP_FADDR_W-1:0]  flash_addr,
   output reg                       flash_req,
   input  wire [`PFRP_WORD_W-1:0]   flash_word,
   output reg                       skip_instr
);
   localparam IDLE  = 2'h0;
   localparam FETCH = 2'h1;
   localparam DONE  = 2'h2;

   reg  [`PFRP_STATE_W-1:0]        state;
   reg  [`PFRP_STATE_W-1:0]        next_state;
   reg  [`PFRP_CNT_W-1:0]          count;
   reg  [`PFRP_CNT_W-1:0]          next_count;
   reg                             start;
   reg                             next_start;
   reg  [`PFRP_BYTE_W-1:0]         data_low;
   reg  [`PFRP_BYTE_W-1:0]         next_data_low;
   reg  [`PFRP_HIGH_DATA_W-1:0]    data_high;
   reg  [`PFRP_HIGH_DATA_W-1:0]    next_data_high;
   reg  [`PFRP_BYTE_W-1:0]         addr_low;
   reg  [`PFRP_BYTE_W-1:0]         next_addr_low;
   reg  [`PFRP_HIGH_ADDR_W-1:0]    addr_high;
   reg  [`PFRP_HIGH_ADDR_W-1:0]    next_addr_high;
   reg  [`PFRP_BYTE_W-1:0]         next_rdata;
   reg  [`PFRP_FADDR_W-1:0]        next_flash_addr;
   reg                             next_flash_req;
   reg                             next_skip_instr;
   wire [`PFRP_REG_COUNT-1:0]      wr_sel;
   wire [`PFRP_REG_COUNT-1:0]      rd_sel;
   wire                            go;
   wire                            fetch_done;

   // one address decode shared by the write and read selects
   function pfrp_addr_hit;
      input [`PFRP_ADDR_W-1:0] addr;
      input integer            ofs;
      begin
         pfrp_addr_hit = ($unsigned(ofs) == {{(`PFRP_INT_W-`PFRP_ADDR_W){1'b0}}, addr});
      end
   endfunction

   genvar i;
   generate
      for (i = 0; i < `PFRP_REG_COUNT; i = i + 1) begin : g_sel
         assign wr_sel[i] = reg_write & pfrp_addr_hit(reg_addr, i);
         assign rd_sel[i] = reg_read & pfrp_addr_hit(reg_addr, i);
      end
   endgenerate

   // start only on a one written while idle; a write of zero is ignored
   assign go = wr_sel[`PFRP_OFS_CONTROL] && reg_wdata[`PFRP_START_BIT] && !start;
   assign fetch_done = (state == FETCH) && (count == `PFRP_FETCH_CYCLES);

   always @* begin
      next_state = state;
      case (state)
         IDLE: begin
            if (go) begin
               next_state = FETCH;
            end
         end
         FETCH: begin
            if (fetch_done) begin
               next_state = DONE;
            end
         end
         DONE: begin
            next_state = IDLE;
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   always @* begin
      next_count = count;
      case (state)
         IDLE: begin
            if (go) begin
               next_count = `PFRP_CNT_ONE;
            end
         end
         FETCH: begin
            if (!fetch_done) begin
               next_count = count + `PFRP_CNT_STEP;
            end
         end
         default: begin
            next_count = `PFRP_CNT_ZERO;
         end
      endcase
   end

   always @* begin
      next_start = start;
      case (state)
         IDLE: begin
            if (go) begin
               next_start = 1'b1;
            end
         end
         FETCH: begin
            next_start = start;
         end
         DONE: begin
            // start drops one cycle after the data registers load
            next_start = 1'b0;
         end
         default: begin
            next_start = 1'b0;
         end
      endcase
   end

   always @* begin
      next_flash_addr = flash_addr;
      next_flash_req  = flash_req;
      next_skip_instr = 1'b0;
      case (state)
         IDLE: begin
            if (go) begin
               // no protection gate sits on this path, so protected words read as stored
               next_flash_addr = {addr_high, addr_low};
               next_flash_req  = 1'b1;
            end
         end
         FETCH: begin
            if (fetch_done) begin
               // the cpu drops the second instruction after the start while the array is busy
               next_skip_instr = 1'b1;
               next_flash_req  = 1'b0;
            end
         end
         default: begin
            next_flash_req = 1'b0;
         end
      endcase
   end

   always @* begin
      next_data_low  = data_low;
      next_data_high = data_high;
      if (wr_sel[`PFRP_OFS_DATA_LOW]) begin
         next_data_low = reg_wdata;
      end
      if (wr_sel[`PFRP_OFS_DATA_HIGH]) begin
         next_data_high = reg_wdata[`PFRP_HIGH_DATA_W-1:0];
      end
      // a fetch result overrides a same-cycle software write
      if (fetch_done) begin
         next_data_low  = flash_word[`PFRP_LOW_BYTE_MSB:0];
         next_data_high = flash_word[`PFRP_WORD_W-1:`PFRP_HIGH_FIELD_LSB];
      end
   end

   always @* begin
      next_addr_low  = addr_low;
      next_addr_high = addr_high;
      if (wr_sel[`PFRP_OFS_ADDR_LOW]) begin
         next_addr_low = reg_wdata;
      end
      if (wr_sel[`PFRP_OFS_ADDR_HIGH]) begin
         next_addr_high = reg_wdata[`PFRP_HIGH_ADDR_W-1:0];
      end
   end

   always @* begin
      next_rdata = `PFRP_BYTE_ZERO;
      if (rd_sel[`PFRP_OFS_CONTROL]) begin
         next_rdata                  = `PFRP_CONTROL_RESET;
         next_rdata[`PFRP_START_BIT] = start;
      end
      if (rd_sel[`PFRP_OFS_DATA_LOW]) begin
         next_rdata = data_low;
      end
      if (rd_sel[`PFRP_OFS_DATA_HIGH]) begin
         next_rdata = {`PFRP_HIGH_DATA_PAD, data_high};
      end
      if (rd_sel[`PFRP_OFS_ADDR_LOW]) begin
         next_rdata = addr_low;
      end
      if (rd_sel[`PFRP_OFS_ADDR_HIGH]) begin
         next_rdata = {`PFRP_HIGH_ADDR_PAD, addr_high};
      end
   end

   // clk_en low freezes every register, read data included
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= `PFRP_CNT_ZERO;
      end else if (clk_en) begin
         count <= next_count;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         start <= 1'b0;
      end else if (clk_en) begin
         start <= next_start;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flash_addr <= `PFRP_FADDR_ZERO;
      end else if (clk_en) begin
         flash_addr <= next_flash_addr;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flash_req <= 1'b0;
      end else if (clk_en) begin
         flash_req <= next_flash_req;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         skip_instr <= 1'b0;
      end else if (clk_en) begin
         skip_instr <= next_skip_instr;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_low <= `PFRP_BYTE_ZERO;
      end else if (clk_en) begin
         data_low <= next_data_low;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_high <= `PFRP_HIGH_DATA_ZERO;
      end else if (clk_en) begin
         data_high <= next_data_high;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_low <= `PFRP_BYTE_ZERO;
      end else if (clk_en) begin
         addr_low <= next_addr_low;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_high <= `PFRP_HIGH_ADDR_ZERO;
      end else if (clk_en) begin
         addr_high <= next_addr_high;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `PFRP_BYTE_ZERO;
      end else if (clk_en) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // pfrp_top
`default_nettype wire

// file: hw/pfrp_consts.vh
// constants for the program flash read port
`ifndef PFRP_CONSTS_VH
`define PFRP_CONSTS_VH
`define PFRP_ADDR_W        3
`define PFRP_OFS_CONTROL   3'h0
`define PFRP_OFS_DATA_LOW  3'h1
`define PFRP_OFS_DATA_HIGH 3'h2
`define PFRP_OFS_ADDR_LOW  3'h3
`define PFRP_OFS_ADDR_HIGH 3'h4
`define PFRP_START_BIT     0
`define PFRP_RESERVED_BIT  7
`define PFRP_CONTROL_RESET 8'h80
`define PFRP_WORD_W        14
`define PFRP_FADDR_W       13
`define PFRP_HIGH_DATA_W   6
`define PFRP_HIGH_ADDR_W   5
`define PFRP_FETCH_CYCLES  2'h2
`define PFRP_BYTE_W         8
`define PFRP_BYTE_ZERO      8'h00
`define PFRP_STATE_W        2
`define PFRP_CNT_W          2
`define PFRP_CNT_ZERO       2'h0
`define PFRP_CNT_ONE        2'h1
`define PFRP_CNT_STEP       2'h1
`define PFRP_REG_COUNT      5
`define PFRP_INT_W          32
`define PFRP_LOW_BYTE_MSB   7
`define PFRP_HIGH_FIELD_LSB 8
`define PFRP_HIGH_DATA_ZERO 6'h00
`define PFRP_HIGH_ADDR_ZERO 5'h00
`define PFRP_HIGH_DATA_PAD  2'h0
`define PFRP_HIGH_ADDR_PAD  3'h0
`define PFRP_FADDR_ZERO     13'h0000
`endif

// file: testbench/pfrp_flash.sv
// flash array model for the read port bench
`timescale 1ns/1ps
`default_nettype none
module pfrp_flash(input wire logic [12:0] flash_addr, input wire logic flash_req,
   output logic [13:0] flash_word);
   // idle bus shows inverted data so a late sample is caught
   assign flash_word = {flash_addr[12:7] ^ 6'h2a, flash_addr[7:0]} ^ {14{!flash_req}};
endmodule // pfrp_flash
`default_nettype wire

// file: testbench/pfrp_chk.sv
// assertion checker for the flash read port
`timescale 1ns/1ps
`default_nettype none
module pfrp_chk(input wire logic core_clk, rst, reg_write, reg_read, flash_req, skip_instr,
   input wire logic [2:0] reg_addr, input wire logic [7:0] reg_wdata, reg_rdata,
   input wire logic [12:0] flash_addr);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_go;
      reg_write && reg_addr == 3'h0 && reg_wdata[0] && !flash_req && !skip_instr;
   endsequence
   sequence s_fetch;
      flash_req [*2] ##1 (skip_instr && !flash_req);
   endsequence
   a_fetch_len: assert property (s_go |=> s_fetch) else $error("fetch");
   a_start_only:
      assert property ($rose(flash_req) |-> $past(reg_write && reg_addr == 3'h0 && reg_wdata[0]))
         else $error("go");
   a_addr_hold:
      assert property (flash_req && $past(flash_req) |-> $stable(flash_addr)) else $error("ad");
   a_ctrl_zero:
      assert property ($past(reg_read && reg_addr == 3'h0) |-> reg_rdata[6:1] == 6'h0) else $error("c");
   a_high_zero:
      assert property ($past(reg_read && reg_addr == 3'h2) |-> reg_rdata[7:6] == 2'h0) else $error("h");
   a_done_clear:
      assert property ($past(skip_instr) && reg_read && reg_addr == 3'h0 |=> !reg_rdata[0])
         else $error("d");
   a_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h0) else $error("z");
endmodule // pfrp_chk
bind pfrp_top pfrp_chk u_chk(.core_clk, .rst, .reg_write, .reg_read, .flash_req, .skip_instr,
   .reg_addr, .reg_wdata, .reg_rdata, .flash_addr);
`default_nettype wire

// file: testbench/pfrp_top_tb.sv
// self-checking bench for the flash read port
`timescale 1ns/1ps
`default_nettype none
module pfrp_top_tb;
   logic        core_clk, rst, reg_write, reg_read, flash_req, skip_instr;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, r;
   logic [12:0] flash_addr, a;
   logic [13:0] flash_word;
   int          err_count, total_checks, n;
   pfrp_top u_pfrp_top(.core_clk, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .flash_addr, .flash_req, .flash_word, .skip_instr);
   pfrp_flash u_pfrp_flash(.flash_addr, .flash_req, .flash_word);
   task bus(input logic w, q, input logic [2:0] ad, input logic [7:0] d);
      @(posedge core_clk) {reg_write, reg_read, reg_addr, reg_wdata} <= {w, q, ad, d};
   endtask
   task rd(input logic [2:0] ad);
      bus(0, 1, ad, 0);
      bus(0, 0, ad, 0);
      #1 r = reg_rdata;
   endtask
   task chk(input logic [7:0] e);
      total_checks++;
      if (r !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, r, e);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      {reg_write, reg_read, reg_addr, reg_wdata, r} = 0;
      rst = 1;
      repeat (12) @(posedge core_clk);
      rst <= 0;
      rd(0);
      chk(8'h80);
      rd(5);
      chk(8'h00);
      bus(1, 0, 0, 8'hfe);
      rd(0);
      chk(8'h80);
      for (n = 0; n < 2; n++) begin
         a = n ? 13'h1fff : 13'h0a5a;
         bus(1, 0, 3, a[7:0]);
         bus(1, 0, 4, {3'h7, a[12:8]});
         bus(1, 0, 0, 8'h01);
         bus(1, 0, 0, 8'h00);
         rd(0);
         chk(8'h81);
         for (int k = 0; k < 9 && r !== 8'h80; k++) rd(0);
         chk(8'h80);
         rd(1);
         chk(a[7:0]);
         rd(2);
         chk({2'h0, a[12:7] ^ 6'h2a});
      end
      give_verdict();
   end
endmodule // pfrp_top_tb
`default_nettype wire
